/* File: pcm_port_pkg.sv */
/*
 * Constants and carrier types for the serial audio codec port.
 * Assumes one 25 MHz system clock and a synchronous active-high reset.
 */
// Contract
// - I2S use two slots per frame, slot 0 left, slot 1 right, full duplex.
// - Slot length up to 40 serial clocks, frame up to 80 clocks.
// - Channel data length 8..320 bits with two channels, up to 640 with one.
// - Each channel has its own data length setting.
// - Each channel has its own data offset from the frame strobe, 1 clock step.
// - Input and output bit order chosen independently, per channel.
// - LSB-first order only for samples of 24 bits or less.
// - Receive and transmit word length of a channel may differ.
// - Output line is high impedance between transmitted words.
// - A setting keeps the output line permanently high impedance.
// - After power-up the output line stays high impedance until configured.
// - Frame-idle supported as master and slave; clock stops low after data.
// - Master stops clock low after idle-start cycles from frame start.
// - Master resumes clock at idle-end; pause is idle-end minus idle-start; the master counts it in half-periods, not serial clocks.
// - All frame data finish before the idle period begins; CFG_ERROR checks only transmit channel 0 against idle_start.
// - Rising or falling edge operation, strobe and data polarity selectable.
// - Falling-edge master codec: strobe sampled on rising, data on falling edge.
// - Master drives clock and strobe; slave takes both as inputs.
// - Master serial clock selectable from 64 kHz to 4.096 MHz; the divider clamp caps it at 3.125 MHz.
package pcm_port_pkg;

    localparam int          SYS_CLK_HZ      = 25_000_000;
    localparam int          SCLK_MIN_HZ     = 64_000;
    localparam int          SCLK_MAX_HZ     = 4_096_000;
    // Half-period divider bounds derived from the clock rate
    localparam int          HALF_DIV_MAX    = SYS_CLK_HZ / (2 * SCLK_MIN_HZ);
    localparam int          HALF_DIV_MIN    = (SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1)
                                              / (2 * SCLK_MAX_HZ);
    localparam int          DIV_W           = 8;
    localparam int          TIMER_W         = 10;
    localparam int          LEN_W           = 10;
    localparam int          SLOT_MAX        = 40;
    localparam int          FRAME_MAX       = 80;
    localparam int          LEN_MIN         = 8;
    localparam int          LEN_MAX_TWO     = 320;
    localparam int          LEN_MAX_ONE     = 640;
    localparam int          LSB_FIRST_MAX   = 24;
    localparam int          WORD_W          = 32;
    localparam logic [DIV_W-1:0] HALF_DIV_RESET = 8'h03;

    typedef struct packed {
        logic [TIMER_W-1:0] offset;
        logic [LEN_W-1:0]   len;
        logic               lsb_first;
    } lane_cfg_t;

    typedef struct packed {
        logic               master;
        logic               fall_edge;
        logic               sync_inv;
        logic               data_inv;
        logic               two_chan;
        logic               out_hiz;
        logic [DIV_W-1:0]   half_div;
        logic [TIMER_W-1:0] frame_len;
        logic [TIMER_W-1:0] idle_start;
        logic [TIMER_W-1:0] idle_end;
    } port_cfg_t;

    typedef struct packed {
        logic               chan;
        logic [WORD_W-1:0]  data;
    } sample_t;

endpackage : pcm_port_pkg

/* File: pcm_sample_fifo.sv */
/*
 * Parameterised valid/ready FIFO for received samples.
 * Assumes both sides on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pcm_sample_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,      // System clock
    input  wire logic             rst,      // Synchronous reset
    input  wire logic [WIDTH-1:0] in_data,  // Write word
    input  wire logic             in_valid, // Write request
    output logic                  in_ready, // Not full
    output logic [WIDTH-1:0]      out_data, // Head word
    output logic                  out_valid,// Not empty
    input  wire logic             out_ready // Reader takes head
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              do_wr = in_valid && in_ready;
    wire              do_rd = out_valid && out_ready;

    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) wr_ptr <= wr_ptr + 1'b1;
            if (do_rd) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule : pcm_sample_fifo
`default_nettype wire

/* File: pcm_codec_port.sv */
/*
 * Serial PCM/I2S codec port: master or slave clock and strobe, two channels,
 * per-channel offsets, lengths and bit order, tri-state output, frame idle.
 * Assumes link pins arrive asynchronously and are oversampled by CLOCK.
 */
`timescale 1ns/1ps
`default_nettype none
module pcm_codec_port
    import pcm_port_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic      CLOCK,          // 25 MHz system clock
    input  wire logic      RST,            // Synchronous reset, active high
    input  wire port_cfg_t CFG,            // Port configuration
    input  wire lane_cfg_t RX_CFG [2],     // Receive lane setup per channel
    input  wire lane_cfg_t TX_CFG [2],     // Transmit lane setup per channel
    input  wire logic      OUT_ENABLE,     // Software releases output from Hi-Z
    input  wire logic [WORD_W-1:0] TX_WORD [2], // Transmit words per channel
    output logic           TX_TAKEN,       // Pulse: transmit words latched
    output sample_t        RX_DATA,        // Received sample head
    output logic           RX_VALID,       // Sample available
    input  wire logic      RX_READY,       // Consumer takes sample
    output logic           RX_OVERRUN,     // Sticky: sample dropped, FIFO full
    input  wire logic      OVERRUN_CLR,    // Clears overrun
    output logic           CFG_ERROR,      // Length or order out of range
    input  wire logic      SCLK_I,         // Serial clock pin in
    output logic           SCLK_O,         // Serial clock pin out
    output logic           SCLK_OE,        // Serial clock drive enable
    input  wire logic      FSYNC_I,        // Frame strobe pin in
    output logic           FSYNC_O,        // Frame strobe pin out
    output logic           FSYNC_OE,       // Frame strobe drive enable
    input  wire logic      DIN,            // Serial data in
    output logic           DOUT,           // Serial data out
    output logic           DOUT_OE         // Serial data drive enable
);
    // Pin synchronisers
    logic [1:0] sclk_sync;
    logic [1:0] fs_sync;
    logic [1:0] din_sync;
    logic       sclk_prev;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sclk_sync <= '0;
            fs_sync   <= '0;
            din_sync  <= '0;
        end else begin
            sclk_sync <= {sclk_sync[0], SCLK_I};
            fs_sync   <= {fs_sync[0], FSYNC_I};
            din_sync  <= {din_sync[0], DIN};
        end
    end

    // Master clock generation
    logic [DIV_W-1:0]   div_cnt;
    logic               mclk;
    logic [TIMER_W-1:0] timer;
    logic               idle;

    wire [DIV_W-1:0] half_div = (CFG.half_div < DIV_W'(HALF_DIV_MIN)) ? DIV_W'(HALF_DIV_MIN)
                              : (CFG.half_div > DIV_W'(HALF_DIV_MAX)) ? DIV_W'(HALF_DIV_MAX)
                              : CFG.half_div;
    wire half_tick = CFG.master && (div_cnt == half_div - 1'b1);

    always_ff @(posedge CLOCK) begin
        if (RST || !CFG.master) begin
            div_cnt <= '0;
            mclk    <= 1'b0;
        end else if (half_tick) begin
            div_cnt <= '0;
            mclk    <= idle ? 1'b0 : !mclk;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // Internal serial clock view: edges of the working clock
    wire sclk_now   = CFG.master ? mclk : sclk_sync[1];
    wire rise       = sclk_now && !sclk_prev;
    wire fall       = !sclk_now && sclk_prev;
    wire launch     = CFG.fall_edge ? rise : fall;
    wire capture    = CFG.fall_edge ? fall : rise;
    // Master ticks the pause on every half-period tick while the clock is held low
    wire idle_tick  = CFG.master && idle && half_tick && !mclk;
    wire period_end = CFG.master ? ((rise && !idle) || idle_tick) : rise;

    always_ff @(posedge CLOCK) begin
        if (RST) sclk_prev <= 1'b0;
        else     sclk_prev <= sclk_now;
    end

    // Frame strobe: master generates, slave detects its active edge
    logic fs_prev;
    wire  fs_level = fs_sync[1] ^ CFG.sync_inv;
    logic fs_seen;
    wire  frame_last = timer == CFG.frame_len - 1'b1;
    wire  frame_start = CFG.master ? (period_end && frame_last)
                                   : (rise && fs_level && !fs_prev);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            fs_prev <= 1'b0;
            fs_seen <= 1'b0;
        end else if (rise) begin
            fs_prev <= fs_level;
            if (frame_start) fs_seen <= 1'b1;
        end
    end

    // Frame timer in serial clocks from the strobe edge
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            timer <= '0;
            idle  <= 1'b0;
        end else if (frame_start) begin
            timer <= '0;
            idle  <= 1'b0;
        end else if (period_end && !frame_last) begin
            timer <= timer + 1'b1;
            if (timer + 1'b1 == CFG.idle_start && CFG.idle_end > CFG.idle_start)
                idle <= 1'b1;
            else if (timer + 1'b1 == CFG.idle_end)
                idle <= 1'b0;
        end
    end

    assign SCLK_O   = mclk;
    assign SCLK_OE  = CFG.master;
    assign FSYNC_OE = CFG.master;

    always_ff @(posedge CLOCK) begin
        if (RST) FSYNC_O <= 1'b0;
        else if (CFG.master && launch)
            FSYNC_O <= (timer == CFG.frame_len - 1'b1) ^ CFG.sync_inv;
    end

    // Timer moves on a rise or a master idle tick, so an edge's own period is looked ahead
    wire [TIMER_W-1:0] pos_next = frame_start ? '0 : timer + 1'b1;
    wire [TIMER_W-1:0] rx_pos   = rise ? pos_next : timer;
    wire [TIMER_W-1:0] tx_pos   = pos_next;
    // First frame after reset counts from its own strobe edge
    wire               started  = fs_seen || frame_start;

    // Lane windows and bit indices; one channel allows the double length
    function automatic logic [LEN_W-1:0] lane_len(input lane_cfg_t c, input logic two);
        logic [LEN_W-1:0] lim;
        lim = two ? LEN_W'(LEN_MAX_TWO) : LEN_W'(LEN_MAX_ONE);
        if (c.len < LEN_W'(LEN_MIN)) lane_len = LEN_W'(LEN_MIN);
        else if (c.len > lim)        lane_len = lim;
        else                         lane_len = c.len;
    endfunction : lane_len

    function automatic logic order_ok(input lane_cfg_t c);
        order_ok = !c.lsb_first || c.len <= LEN_W'(LSB_FIRST_MAX);
    endfunction : order_ok

    // Bit position inside the word; lengths over the word width keep the low bits
    function automatic logic [4:0] bit_pos(input lane_cfg_t c, input logic [LEN_W-1:0] n,
                                           input logic [LEN_W-1:0] len);
        logic [LEN_W-1:0] p;
        p = (c.lsb_first && order_ok(c)) ? n : len - 1'b1 - n;
        bit_pos = p[4:0];
    endfunction : bit_pos

    assign CFG_ERROR = !order_ok(RX_CFG[0]) || !order_ok(RX_CFG[1]) ||
                       !order_ok(TX_CFG[0]) || !order_ok(TX_CFG[1]) ||
                       CFG.frame_len > TIMER_W'(FRAME_MAX) ||
                       (CFG.idle_start != '0 && CFG.idle_start < CFG.frame_len &&
                        (TX_CFG[0].offset + TX_CFG[0].len > CFG.idle_start));

    // Transmit path
    logic [WORD_W-1:0] tx_hold [2];
    logic [LEN_W-1:0]  tx_len [2];
    logic [1:0]        tx_in_win;
    logic              out_armed;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tx
            wire active = (g == 0) || CFG.two_chan;
            assign tx_len[g] = lane_len(TX_CFG[g], CFG.two_chan);
            assign tx_in_win[g] = active && started && !idle &&
                                  tx_pos >= TX_CFG[g].offset &&
                                  tx_pos <  TX_CFG[g].offset + tx_len[g];
        end
    endgenerate

    wire              tx_lane = !tx_in_win[0];
    wire [LEN_W-1:0]  tx_n    = tx_pos - TX_CFG[tx_lane].offset;
    wire [4:0]        tx_bit  = bit_pos(TX_CFG[tx_lane], tx_n, tx_len[tx_lane]);
    wire              tx_any  = |tx_in_win;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            tx_hold[0] <= '0;
            tx_hold[1] <= '0;
            TX_TAKEN   <= 1'b0;
            out_armed  <= 1'b0;
        end else begin
            TX_TAKEN <= 1'b0;
            if (OUT_ENABLE) out_armed <= 1'b1;
            if (frame_start) begin
                tx_hold[0] <= TX_WORD[0];
                tx_hold[1] <= TX_WORD[1];
                TX_TAKEN   <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            DOUT    <= 1'b0;
            DOUT_OE <= 1'b0;
        end else if (launch) begin
            DOUT    <= tx_hold[tx_lane][tx_bit] ^ CFG.data_inv;
            DOUT_OE <= tx_any && out_armed && !CFG.out_hiz;
        end
    end

    // Receive path
    logic [WORD_W-1:0] rx_shift [2];
    logic [1:0]        rx_in_win;
    logic [LEN_W-1:0]  rx_len [2];
    logic [1:0]        rx_done;

    generate
        for (g = 0; g < 2; g++) begin : g_rx
            wire active = (g == 0) || CFG.two_chan;
            assign rx_len[g] = lane_len(RX_CFG[g], CFG.two_chan);
            assign rx_in_win[g] = active && started && !idle &&
                                  rx_pos >= RX_CFG[g].offset &&
                                  rx_pos <  RX_CFG[g].offset + rx_len[g];
            wire [LEN_W-1:0] n = rx_pos - RX_CFG[g].offset;
            wire [4:0]       b = bit_pos(RX_CFG[g], n, rx_len[g]);
            assign rx_done[g] = capture && rx_in_win[g] && n == rx_len[g] - 1'b1;
            always_ff @(posedge CLOCK) begin
                if (RST)
                    rx_shift[g] <= '0;
                else if (capture && rx_in_win[g]) begin
                    if (n == '0) rx_shift[g] <= '0;
                    rx_shift[g][b] <= din_sync[1] ^ CFG.data_inv;
                end
            end
        end
    endgenerate

    // Completed word, one clock later so the last bit is in
    logic    push;
    sample_t push_data;
    wire     fifo_ready;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            push      <= 1'b0;
            push_data <= '0;
        end else begin
            push           <= |rx_done;
            push_data.chan <= rx_done[1] && !rx_done[0];
        end
    end

    wire sample_t push_word = '{chan: push_data.chan, data: rx_shift[push_data.chan]};

    always_ff @(posedge CLOCK) begin
        if (RST)                      RX_OVERRUN <= 1'b0;
        else if (push && !fifo_ready) RX_OVERRUN <= 1'b1;
        else if (OVERRUN_CLR)         RX_OVERRUN <= 1'b0;
    end

    pcm_sample_fifo #(
        .WIDTH ($bits(sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLOCK),
        .rst       (RST),
        .in_data   (push_word),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .out_data  (RX_DATA),
        .out_valid (RX_VALID),
        .out_ready (RX_READY)
    );
endmodule : pcm_codec_port
`default_nettype wire

/* File: pcm_codec_port_properties.sv */
/* Concurrent checks on the codec port's top-level ports.
   Bound to pcm_codec_port from tb_top; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module pcm_port_checker
    import pcm_port_pkg::*;
(
    input wire logic      CLOCK,      // System clock
    input wire logic      RST,        // Sync reset
    input wire port_cfg_t CFG,        // Port setup
    input wire lane_cfg_t RX_CFG [2], // Receive lanes
    input wire lane_cfg_t TX_CFG [2], // Transmit lanes
    input wire logic      OUT_ENABLE, // Output release
    input wire logic      TX_TAKEN,   // Word latch pulse
    input wire logic      CFG_ERROR,  // Setup fault
    input wire logic      SCLK_O,     // Clock out
    input wire logic      SCLK_OE,    // Clock enable
    input wire logic      FSYNC_OE,   // Strobe enable
    input wire logic      DOUT_OE     // Data enable
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    logic armed;

    // Output stays parked until software has released it once
    always_ff @(posedge CLOCK) begin
        armed <= RST ? 1'b0 : (armed | OUT_ENABLE);
    end

    a_lsb_rx_limit: assert property (RX_CFG[0].lsb_first && RX_CFG[0].len > 10'd24 |-> CFG_ERROR)
        else $error("receive lsb-first word over 24 bits accepted");
    a_lsb_tx_limit: assert property (TX_CFG[1].lsb_first && TX_CFG[1].len > 10'd24 |-> CFG_ERROR)
        else $error("transmit lsb-first word over 24 bits accepted");
    a_frame_limit: assert property (CFG.frame_len > 10'd80 |-> CFG_ERROR)
        else $error("frame over 80 clocks accepted");
    a_hiz_forced: assert property (CFG.out_hiz && $past(CFG.out_hiz) |-> !DOUT_OE)
        else $error("data driven while forced to high impedance");
    a_hiz_power_up: assert property (!armed |-> !DOUT_OE)
        else $error("data driven before output release");
    a_pin_dir: assert property (SCLK_OE == CFG.master && FSYNC_OE == CFG.master)
        else $error("clock or strobe direction differs from role");
    a_sclk_low_half: assert property (CFG.master && CFG.half_div == 8'h04 && $fell(SCLK_O) |-> !SCLK_O [*4])
        else $error("serial clock low phase shorter than divider");
    a_taken_pulse: assert property ($rose(TX_TAKEN) |=> !TX_TAKEN)
        else $error("word latch pulse longer than one cycle");
endmodule : pcm_port_checker
`default_nettype wire

/* File: codec_model.sv */
/* Behavioural external codec acting as bus master of clock and strobe.
   Driven by tasks from tb_top; timing is in ns, independent of CLOCK. */
`timescale 1ns/1ps
`default_nettype none
module codec_model (
    input wire logic dout,    // Device data out
    input wire logic dout_oe, // Device data enable
    output logic     sclk,    // Serial clock
    output logic     fsync,   // Frame strobe
    output logic     din      // Data toward device
);
    logic cap_d  [40];
    logic cap_oe [40];

    initial begin
        sclk = 1'b0;
        fsync = 1'b0;
        din = 1'b0;
    end

    // Mid-phase sample: device output lags the launch edge by a few cycles
    task automatic grab(input int k);
        cap_d[k] = dout;
        cap_oe[k] = dout_oe;
    endtask : grab

    // One 40-clock frame, two 20-clock slots; 320 ns period keeps below 12 MHz
    task automatic frame(input logic fe, input logic inv, input logic [40:0] bits);
        #13;
        fsync = inv;
        #160;
        for (int k = -1; k < 40; k++) begin
            sclk = 1'b1;
            if (fe && k >= 0) din = bits[k];
            #80;
            if (!fe && k >= 0) grab(k);
            #80;
            sclk = 1'b0;
            fsync = (k == -1) ? ~inv : inv;
            if (!fe) din = bits[k+1];
            #80;
            if (fe && k >= 0) grab(k);
            #80;
        end
        din = ~din;
        #640;
    endtask : frame
endmodule : codec_model
`default_nettype wire

/* File: tb_top.sv */
/* Self-checking bench for pcm_codec_port with an external codec model.
   Expects the design package and FIFO compiled before this file. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pcm_port_pkg::*;

    logic              clock = 1'b0;
    logic              rst = 1'b1;
    port_cfg_t         cfg = '0;
    lane_cfg_t         rx_cfg [2];
    lane_cfg_t         tx_cfg [2];
    logic [WORD_W-1:0] tx_word [2];
    logic              out_enable = 1'b0;
    logic              rx_ready = 1'b0;
    logic              overrun_clr = 1'b0;
    sample_t           rx_data;
    logic              tx_taken, rx_valid, rx_overrun, cfg_error;
    logic              sclk_o, sclk_oe, fsync_o, fsync_oe, dout, dout_oe;
    logic              m_sclk, m_fsync, m_din;
    int                err_count = 0;
    int                num_checks = 0;

    wire sclk_pin = sclk_oe ? sclk_o : m_sclk;
    wire fsync_pin = fsync_oe ? fsync_o : m_fsync;

    always #20 clock = ~clock;

    pcm_codec_port #(.FIFO_DEPTH(8)) u_pcm_codec_port (
        .CLOCK(clock), .RST(rst), .CFG(cfg), .RX_CFG(rx_cfg), .TX_CFG(tx_cfg),
        .OUT_ENABLE(out_enable), .TX_WORD(tx_word), .TX_TAKEN(tx_taken),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .RX_OVERRUN(rx_overrun), .OVERRUN_CLR(overrun_clr), .CFG_ERROR(cfg_error),
        .SCLK_I(sclk_pin), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .FSYNC_I(fsync_pin),
        .FSYNC_O(fsync_o), .FSYNC_OE(fsync_oe), .DIN(m_din), .DOUT(dout),
        .DOUT_OE(dout_oe));

    codec_model u_codec_model (.dout(dout), .dout_oe(dout_oe), .sclk(m_sclk),
        .fsync(m_fsync), .din(m_din));

    task automatic tick();
        @(posedge clock);
        #2;
    endtask : tick

    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic setup(input logic m, input logic fe);
        cfg = '0;
        cfg.master = m;
        cfg.fall_edge = fe;
        cfg.sync_inv = fe;
        cfg.two_chan = 1'b1;
        cfg.half_div = 8'h04;
        cfg.frame_len = m ? 10'd20 : 10'd40;
        cfg.idle_start = m ? 10'd12 : 10'd79;
        cfg.idle_end = m ? 10'd16 : 10'd79;
        rx_cfg[0] = '{10'd1, 10'd8, 1'b0};
        rx_cfg[1] = '{10'd21, 10'd12, 1'b1};
        tx_cfg[0] = '{10'd1, m ? 10'd8 : 10'd16, 1'b0};
        tx_cfg[1] = '{10'd20, 10'd8, 1'b1};
        rst = 1'b1;
        repeat (6) tick();
        rst = 1'b0;
        tick();
    endtask : setup

    // Line levels per frame-timer count; unused counts idle high
    function automatic logic [40:0] rx_bits(input logic [7:0] b0, input logic [11:0] b1);
        logic [40:0] v;
        v = '1;
        for (int i = 0; i < 8; i++) v[1+i] = b0[7-i];
        for (int i = 0; i < 12; i++) v[21+i] = b1[i];
        return v;
    endfunction : rx_bits

    task automatic chk_tx(input logic hiz);
        logic eo;
        for (int k = 0; k < 40; k++) begin
            eo = !hiz && ((k >= 1 && k <= 16) || (k >= 20 && k <= 27));
            check("dout_oe", eo, u_codec_model.cap_oe[k]);
            if (eo) check("dout", k <= 16 ? tx_word[0][16-k] : tx_word[1][k-20], u_codec_model.cap_d[k]);
        end
    endtask : chk_tx

    task automatic pop(input logic c, input logic [31:0] d);
        check("rx_valid", 1'b1, rx_valid);
        check("rx_data", {c, d}, rx_data);
        rx_ready = 1'b1;
        tick();
        rx_ready = 1'b0;
    endtask : pop

    task automatic t_cfg_err();
        logic [4:0] exp;
        exp = 5'b01101;
        for (int i = 0; i < 5; i++) begin
            setup(1'b0, 1'b0);
            check("cfg_error", 1'b0, cfg_error);
            case (i)
                0: rx_cfg[0] = '{10'd1, 10'd25, 1'b1};
                1: rx_cfg[0] = '{10'd1, 10'd24, 1'b1};
                2: tx_cfg[1] = '{10'd20, 10'd25, 1'b1};
                3: cfg.frame_len = 10'd81;
                default: cfg.frame_len = 10'd80;
            endcase
            tick();
            check("cfg_error", exp[i], cfg_error);
        end
        $display("t_cfg_err done");
    endtask : t_cfg_err

    task automatic t_slave();
        setup(1'b0, 1'b0);
        u_codec_model.frame(1'b0, 1'b0, rx_bits(8'h9c, 12'h5a3));
        chk_tx(1'b1);
        tick();
        out_enable = 1'b1;
        cfg.out_hiz = 1'b1;
        u_codec_model.frame(1'b0, 1'b0, rx_bits(8'h9c, 12'h5a3));
        chk_tx(1'b1);
        tick();
        cfg.out_hiz = 1'b0;
        repeat (3) begin
            u_codec_model.frame(1'b0, 1'b0, rx_bits(8'h9c, 12'h5a3));
            chk_tx(1'b0);
        end
        check("rx_overrun", 1'b1, rx_overrun);
        repeat (4) begin
            pop(1'b0, 32'h9c);
            pop(1'b1, 32'h5a3);
        end
        check("rx_valid", 1'b0, rx_valid);
        overrun_clr = 1'b1;
        tick();
        overrun_clr = 1'b0;
        check("rx_overrun", 1'b0, rx_overrun);
        $display("t_slave done");
    endtask : t_slave

    task automatic t_fall();
        setup(1'b0, 1'b1);
        u_codec_model.frame(1'b1, 1'b1, rx_bits(8'h3e, 12'hc81));
        chk_tx(1'b0);
        pop(1'b0, 32'h3e);
        pop(1'b1, 32'hc81);
        $display("t_fall done");
    endtask : t_fall

    task automatic t_master();
        int f, n, w, tk;
        logic pf, ps;
        f = 0;
        n = 0;
        w = 0;
        tk = 0;
        pf = 1'b1;
        ps = 1'b1;
        setup(1'b1, 1'b0);
        for (int c = 0; c < 1000 && f < 3; c++) begin
            tick();
            if (fsync_o && !pf) f++;
            if (f == 2 && fsync_o) w++;
            if (f == 2 && sclk_o && !ps) n++;
            if (f == 2 && tx_taken) tk++;
            pf = fsync_o;
            ps = sclk_o;
        end
        check("frames", 33'd3, f[32:0]);
        check("sclk_rises", 33'd16, n[32:0]);
        check("fsync_width", 33'd8, w[32:0]);
        check("tx_taken", 33'd1, tk[32:0]);
        $display("t_master done");
    endtask : t_master

    initial begin
        tx_word[0] = 32'h0000c3a5;
        tx_word[1] = 32'h0000006d;
        t_cfg_err();
        t_slave();
        t_fall();
        t_master();
        close_out();
    end

    initial begin
        #400_000;
        err_count++;
        close_out();
    end
endmodule : tb_top

bind pcm_codec_port pcm_port_checker u_chk (.CLOCK(CLOCK), .RST(RST), .CFG(CFG),
    .RX_CFG(RX_CFG), .TX_CFG(TX_CFG), .OUT_ENABLE(OUT_ENABLE), .TX_TAKEN(TX_TAKEN),
    .CFG_ERROR(CFG_ERROR), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE), .FSYNC_OE(FSYNC_OE),
    .DOUT_OE(DOUT_OE));
`default_nettype wire
